/* hw/swi_serdes_word.sv */
// Parallel word side of a 10-bit serializer/deserializer with bus registers
`include "swi_consts.svh"
`default_nettype none
module swi_serdes_word import swi_pkg::*; (
	// Clock and reset
	input  wire logic                   CLK_SYS,
	input  wire logic                   NRST,
	// Transmit character side
	input  wire logic                   REFERENCE_CLOCK_IN,
	input  wire logic [`SWI_CHAR_W-1:0] TX_CHAR,
	// Serial line
	output var  logic                   TX_SERIAL_P,
	output var  logic                   TX_SERIAL_N,
	input  wire logic                   RX_SERIAL,
	// Control pins
	input  wire logic                   LOOPBACK_SELECT,
	input  wire logic                   ALIGN_ENABLE,
	// Receive word side
	output var  logic [`SWI_CHAR_W-1:0] RX_WORD,
	output var  logic                   RECOVERED_WORD_CLOCK,
	output var  logic                   RECOVERED_WORD_CLOCK_INV,
	output var  logic                   COMMA_FLAG,
	output var  logic                   SIGNAL_VALID,
	// AHB-Lite slave
	input  wire logic                   HSEL,
	input  wire logic [31:0]            HADDR,
	input  wire logic [1:0]             HTRANS,
	input  wire logic                   HWRITE,
	input  wire logic [2:0]             HSIZE,
	input  wire logic [31:0]            HWDATA,
	input  wire logic                   HREADY,
	output var  logic [31:0]            HRDATA,
	output var  logic                   HREADYOUT,
	output var  logic                   HRESP,
	// Interrupt
	output var  logic                   IRQ
);

	// ****************************************
	// Pin synchronisation
	// ****************************************
	logic [`SWI_SYNC_W-1:0] pins_s;
	logic                   ref_s, rx_s, loop_pin_s, align_pin_s;

	swi_sync #(.W(`SWI_SYNC_W)) u_sync (
		.clk      (CLK_SYS),
		.nrst     (NRST),
		.async_in ({ALIGN_ENABLE, LOOPBACK_SELECT, RX_SERIAL, REFERENCE_CLOCK_IN}),
		.sync_out (pins_s)
	);
	assign {align_pin_s, loop_pin_s, rx_s, ref_s} = pins_s;

	logic [`SWI_CTRL_W-1:0] ctrl_reg;
	logic                   loop_act, align_act;
	assign loop_act  = loop_pin_s | ctrl_reg[`SWI_CTRL_LOOP];
	assign align_act = align_pin_s | ctrl_reg[`SWI_CTRL_ALIGN];

	// ****************************************
	// Transmit capture and serializer
	// ****************************************
	logic                   ref_prev_reg, ref_rise;
	logic [`SWI_CHAR_W-1:0] tx_sr_reg, tx_hold_reg;
	logic                   tx_bit_reg;

	assign ref_rise = ref_s & ~ref_prev_reg;

	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			ref_prev_reg <= 1'b0;
			tx_sr_reg    <= '0;
			tx_hold_reg  <= '0;
			tx_bit_reg   <= 1'b0;
		end else begin
			ref_prev_reg <= ref_s;
			if (ref_rise) begin
				tx_hold_reg <= TX_CHAR;
				tx_bit_reg  <= TX_CHAR[0];
				tx_sr_reg   <= {1'b0, TX_CHAR[`SWI_CHAR_W-1:1]};
			end else begin
				// One bit per system clock: ten per reference period
				tx_bit_reg <= tx_sr_reg[0];
				tx_sr_reg  <= {1'b0, tx_sr_reg[`SWI_CHAR_W-1:1]};
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			TX_SERIAL_P <= 1'b1;
			TX_SERIAL_N <= 1'b0;
		end else if (loop_act) begin
			TX_SERIAL_P <= 1'b1;
			TX_SERIAL_N <= 1'b0;
		end else begin
			TX_SERIAL_P <= tx_bit_reg;
			TX_SERIAL_N <= ~tx_bit_reg;
		end
	end

	// ****************************************
	// Receive path select and deserializer
	// ****************************************
	logic                   rx_bit;
	logic [`SWI_CHAR_W-1:0] rx_sr_reg, rx_window;
	logic [3:0]             rx_cnt_reg;
	logic                   comma_seen, realign, slip, word_done, word_comma;

	assign rx_bit     = loop_act ? tx_bit_reg : rx_s;
	// Newest bit enters on top, so the oldest ends in bit zero
	assign rx_window  = {rx_bit, rx_sr_reg[`SWI_CHAR_W-1:1]};
	assign comma_seen = rx_window[`SWI_CHAR_W-1:`SWI_CHAR_W-`SWI_COMMA_W] == `SWI_COMMA_PAT;
	assign realign    = align_act && comma_seen && rx_cnt_reg != `SWI_REALIGN_CNT;
	// A realign that would put the comma on the true clock emits a short slip word
	assign slip       = realign && RECOVERED_WORD_CLOCK_INV;
	assign word_done  = (rx_cnt_reg == `SWI_LAST_BIT && !realign) || slip;
	assign word_comma = rx_window[`SWI_COMMA_W-1:0] == `SWI_COMMA_PAT;

	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			rx_sr_reg  <= '0;
			rx_cnt_reg <= 4'h0;
		end else begin
			rx_sr_reg <= rx_window;
			if (realign)
				rx_cnt_reg <= `SWI_REALIGN_LOAD;
			else if (rx_cnt_reg == `SWI_LAST_BIT)
				rx_cnt_reg <= 4'h0;
			else
				rx_cnt_reg <= rx_cnt_reg + 4'h1;
		end
	end

	// ****************************************
	// Word output, recovered clocks, comma flag
	// ****************************************
	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			RX_WORD                  <= '0;
			RECOVERED_WORD_CLOCK     <= 1'b0;
			RECOVERED_WORD_CLOCK_INV <= 1'b1;
		end else if (word_done) begin
			RX_WORD                  <= rx_window;
			// Toggle every ten bits: period of twenty bits
			RECOVERED_WORD_CLOCK     <= ~RECOVERED_WORD_CLOCK;
			RECOVERED_WORD_CLOCK_INV <= RECOVERED_WORD_CLOCK;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!NRST)
			COMMA_FLAG <= 1'b0;
		else if (!align_act)
			COMMA_FLAG <= 1'b0;
		else if (word_done)
			// Rising inverted clock means the true clock is high now
			COMMA_FLAG <= word_comma && RECOVERED_WORD_CLOCK && !slip;
	end

	// ****************************************
	// Signal detect from transition density
	// ****************************************
	logic       rx_prev_reg;
	logic [4:0] run_reg;

	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			rx_prev_reg  <= 1'b0;
			run_reg      <= `SWI_RUN_LIMIT;
			SIGNAL_VALID <= 1'b0;
		end else begin
			rx_prev_reg <= rx_bit;
			if (rx_bit != rx_prev_reg)
				run_reg <= 5'h0;
			else if (run_reg != `SWI_RUN_LIMIT)
				run_reg <= run_reg + 5'h1;
			// Coded data never runs this long; a stuck line is invalid
			SIGNAL_VALID <= run_reg != `SWI_RUN_LIMIT;
		end
	end

	// ****************************************
	// AHB-Lite slave, one wait state per transfer
	// ****************************************
	swi_bus_state_t         bus_state_reg;
	swi_bus_req_t           bus_req_reg;
	logic [`SWI_EVT_W-1:0]  status_reg, mask_reg;
	swi_events_t            evt;
	logic                   status_clr;

	function automatic logic [31:0] read_mux(input logic [7:0] a,
			input logic [`SWI_CTRL_W-1:0] c, input logic [`SWI_EVT_W-1:0] s,
			input logic [`SWI_EVT_W-1:0] m, input logic [`SWI_CHAR_W-1:0] w,
			input logic v, input logic k);
		logic [31:0] d;
		d = 32'h0000_0000;
		if (a == `SWI_ADDR_CTRL)
			d[`SWI_CTRL_W-1:0] = c;
		else if (a == `SWI_ADDR_STATUS)
			d[`SWI_EVT_W-1:0] = s;
		else if (a == `SWI_ADDR_MASK)
			d[`SWI_EVT_W-1:0] = m;
		else if (a == `SWI_ADDR_RXINFO)
			d[`SWI_RXINFO_CLK:0] = {k, v, w};
		return d;
	endfunction

	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			bus_state_reg <= SWI_BUS_IDLE;
			bus_req_reg   <= '0;
			HREADYOUT     <= 1'b1;
			HRDATA        <= 32'h0000_0000;
			HRESP         <= 1'b0;
		end else begin
			HRESP         <= 1'b0; // Every transfer answers OKAY
			case (bus_state_reg)
				SWI_BUS_IDLE: begin
					if (HSEL && HTRANS[1] && HREADY) begin
						bus_req_reg   <= '{addr: HADDR[7:0], write: HWRITE};
						bus_state_reg <= SWI_BUS_DATA;
						HREADYOUT     <= 1'b0;
					end
				end
				SWI_BUS_DATA: begin
					bus_state_reg <= SWI_BUS_IDLE;
					HREADYOUT     <= 1'b1;
					HRDATA        <= bus_req_reg.write ? 32'h0000_0000 :
						read_mux(bus_req_reg.addr, ctrl_reg, status_reg, mask_reg,
						RX_WORD, SIGNAL_VALID, RECOVERED_WORD_CLOCK);
				end
				default: begin
					bus_state_reg <= SWI_BUS_IDLE;
					HREADYOUT     <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			ctrl_reg <= `SWI_CTRL_RST;
			mask_reg <= `SWI_MASK_RST;
		end else if (bus_state_reg == SWI_BUS_DATA && bus_req_reg.write) begin
			if (bus_req_reg.addr == `SWI_ADDR_CTRL)
				ctrl_reg <= HWDATA[`SWI_CTRL_W-1:0];
			else if (bus_req_reg.addr == `SWI_ADDR_MASK)
				mask_reg <= HWDATA[`SWI_EVT_W-1:0];
		end
	end

	// ****************************************
	// Sticky events and interrupt
	// ****************************************
	assign evt.comma    = word_done && align_act && word_comma && RECOVERED_WORD_CLOCK && !slip;
	assign evt.realign  = realign;
	assign evt.sig_lost = SIGNAL_VALID && run_reg == `SWI_RUN_LIMIT;
	assign evt.word     = word_done;
	assign status_clr   = bus_state_reg == SWI_BUS_DATA && !bus_req_reg.write &&
		bus_req_reg.addr == `SWI_ADDR_STATUS;

	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			status_reg <= `SWI_STATUS_RST;
			IRQ        <= 1'b0;
		end else begin
			// New events win over the read that clears
			status_reg <= (status_clr ? `SWI_STATUS_RST : status_reg) | evt;
			IRQ        <= |(((status_clr ? `SWI_STATUS_RST : status_reg) | evt) & mask_reg);
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!NRST);

	sequence s_capture;
		ref_rise ##1 !ref_rise ##1 !ref_rise[*8];
	endsequence

	property p_capture;
		ref_rise |=> tx_hold_reg == $past(TX_CHAR);
	endproperty
	a_capture: assert property (p_capture) else $error("char not captured");

	property p_first_bit;
		ref_rise |=> tx_bit_reg == tx_hold_reg[0];
	endproperty
	a_first_bit: assert property (p_first_bit) else $error("bit zero not first");

	property p_last_bit;
		s_capture |=> tx_bit_reg == tx_hold_reg[`SWI_CHAR_W-1];
	endproperty
	a_last_bit: assert property (p_last_bit) else $error("bit nine not tenth");

	property p_loop_line;
		loop_act |=> TX_SERIAL_P && !TX_SERIAL_N;
	endproperty
	a_loop_line: assert property (p_loop_line) else $error("line not held in loopback");

	property p_line_data;
		!loop_act |=> TX_SERIAL_P == $past(tx_bit_reg) && TX_SERIAL_N != TX_SERIAL_P;
	endproperty
	a_line_data: assert property (p_line_data) else $error("line not carrying data");

	property p_rx_source;
		loop_act ? rx_bit == tx_bit_reg : rx_bit == rx_s;
	endproperty
	a_rx_source: assert property (p_rx_source) else $error("wrong receive source");

	property p_word_out;
		word_done |=> RX_WORD[0] == $past(rx_sr_reg[1]) && $changed(RECOVERED_WORD_CLOCK);
	endproperty
	a_word_out: assert property (p_word_out) else $error("word not delivered");

	property p_clocks;
		RECOVERED_WORD_CLOCK != RECOVERED_WORD_CLOCK_INV;
	endproperty
	a_clocks: assert property (p_clocks) else $error("clocks not complementary");

	property p_no_flag;
		!align_act |=> !COMMA_FLAG;
	endproperty
	a_no_flag: assert property (p_no_flag) else $error("flag while align off");

	property p_flag_word;
		COMMA_FLAG |-> RX_WORD[`SWI_COMMA_W-1:0] == `SWI_COMMA_PAT && RECOVERED_WORD_CLOCK_INV;
	endproperty
	a_flag_word: assert property (p_flag_word) else $error("flag without comma");

	property p_flag_hold;
		$rose(COMMA_FLAG) && !slip |-> (COMMA_FLAG || !align_act)[*8];
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag pulse too short");

	property p_realign;
		realign && !slip |-> ##3 word_done ##1 RX_WORD[`SWI_COMMA_W-1:0] == `SWI_COMMA_PAT;
	endproperty
	a_realign: assert property (p_realign) else $error("comma not at bit zero");

	property p_sig_lost;
		run_reg == `SWI_RUN_LIMIT |=> !SIGNAL_VALID;
	endproperty
	a_sig_lost: assert property (p_sig_lost) else $error("valid on dead line");

endmodule // swi_serdes_word
`default_nettype wire

/* hw/swi_consts.svh */
// Constants for the serdes parallel word interface: offsets, fields, counts
`ifndef SWI_CONSTS_SVH
`define SWI_CONSTS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define SWI_ADDR_CTRL     8'h00
`define SWI_ADDR_STATUS   8'h04
`define SWI_ADDR_MASK     8'h08
`define SWI_ADDR_RXINFO   8'h0c

// ****************************************
// Field positions and reset values
// ****************************************
`define SWI_CTRL_LOOP     0
`define SWI_CTRL_ALIGN    1
`define SWI_CTRL_W        2
`define SWI_CTRL_RST      2'h0
`define SWI_EVT_W         4
`define SWI_MASK_RST      4'h0
`define SWI_STATUS_RST    4'h0
`define SWI_RXINFO_VALID  10
`define SWI_RXINFO_CLK    11

// ****************************************
// Character layout and timing counts
// ****************************************
`define SWI_CHAR_W        10
`define SWI_COMMA_W       7
`define SWI_COMMA_PAT     7'h7c
`define SWI_LAST_BIT      4'h9
`define SWI_REALIGN_CNT   4'h6
`define SWI_REALIGN_LOAD  4'h7
`define SWI_RUN_LIMIT     5'h14
`define SWI_SYNC_W        4

`endif

/* hw/swi_pkg.sv */
// Types shared by the serdes parallel word interface
`default_nettype none
package swi_pkg;

	typedef enum logic [1:0] {
		SWI_BUS_IDLE = 2'b01,
		SWI_BUS_DATA = 2'b10
	} swi_bus_state_t;

	typedef struct packed {
		logic [7:0] addr;
		logic       write;
	} swi_bus_req_t;

	// Same layout as the status and mask registers
	typedef struct packed {
		logic word;
		logic sig_lost;
		logic realign;
		logic comma;
	} swi_events_t;

endpackage
`default_nettype wire

/* hw/swi_sync.sv */
// Two-stage synchroniser for a group of pin inputs
`default_nettype none
module swi_sync import swi_pkg::*; #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic [W-1:0] async_in,
	output var  logic [W-1:0] sync_out
);
	logic [W-1:0] meta_reg;

	// ****************************************
	// One pair of flops per bit
	// ****************************************
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk) begin
				if (!nrst) begin
					meta_reg[i] <= 1'b0;
					sync_out[i] <= 1'b0;
				end else begin
					meta_reg[i] <= async_in[i];
					sync_out[i] <= meta_reg[i];
				end
			end
		end
	endgenerate

endmodule // swi_sync
`default_nettype wire

/* tb/swi_link_ctrl.sv */
// Link-layer controller model: presents characters and takes received words
`default_nettype none
module swi_link_ctrl import swi_pkg::*; (
	// Clock
	input  wire logic        clk,
	// Transmit characters, sent alternately
	input  wire logic [9:0]  char_a,
	input  wire logic [9:0]  char_b,
	output var  logic        ref_clk,
	output var  logic [9:0]  tx_char,
	// Receive words
	input  wire logic [9:0]  rx_word,
	input  wire logic        rclk,
	input  wire logic        rclk_inv,
	output var  logic [9:0]  rx_seen,
	output var  logic [15:0] rx_count
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] div;
	logic       alt;
	logic       rclk_d;
	logic       inv_d;
	initial begin
		{div, alt, rclk_d, inv_d, ref_clk} = 8'h00;
		tx_char = 10'h000;
		rx_seen = 10'h000;
		rx_count = 16'h0000;
	end
	// ****
	// Reference clock, a tenth of clk
	// ****
	always @(posedge clk) begin
		div <= (div == 4'h9) ? 4'h0 : div + 4'h1;
		ref_clk <= (div < 4'h5);
	end
	// Change late in the low phase so the capture edge sees a steady word
	always @(posedge clk) begin
		if (div == 4'h7) begin
			tx_char <= alt ? char_b : char_a;
			alt <= ~alt;
		end
	end
	// One word taken per rise of either recovered clock
	always @(posedge clk) begin
		rclk_d <= rclk;
		inv_d <= rclk_inv;
		if ((rclk && !rclk_d) || (rclk_inv && !inv_d)) begin
			rx_seen <= rx_word;
			rx_count <= rx_count + 16'h0001;
		end
	end
endmodule // swi_link_ctrl
`default_nettype wire

/* tb/swi_serdes_word_tb_top.sv */
// Self-checking bench for the serdes parallel word block
`include "swi_consts.svh"
`default_nettype none
module swi_serdes_word_tb_top import swi_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, nrst, ref_clk, rx_ser, loop_sel, align_en, ext_on;
	logic        tx_p, tx_n, rclk, rclk_inv, comma, sig_valid, irq;
	logic        hsel, hwrite, hready, hreadyout, hresp;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata;
	logic [9:0]  tx_char, rx_word, char_a, char_b, rx_seen;
	logic [15:0] rx_count;
	logic [4:0]  bi;
	int          num_errors = 0;
	int          comparisons = 0;
	localparam logic [19:0] SER_PAT = {10'h0e3, 10'h27c};
	assign hready = hreadyout;
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	swi_serdes_word uut (
		.CLK_SYS(clk), .NRST(nrst), .REFERENCE_CLOCK_IN(ref_clk), .TX_CHAR(tx_char),
		.TX_SERIAL_P(tx_p), .TX_SERIAL_N(tx_n), .RX_SERIAL(rx_ser),
		.LOOPBACK_SELECT(loop_sel), .ALIGN_ENABLE(align_en), .RX_WORD(rx_word),
		.RECOVERED_WORD_CLOCK(rclk), .RECOVERED_WORD_CLOCK_INV(rclk_inv),
		.COMMA_FLAG(comma), .SIGNAL_VALID(sig_valid), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
		.HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .IRQ(irq)
	);
	swi_link_ctrl partner (
		.clk(clk), .char_a(char_a), .char_b(char_b), .ref_clk(ref_clk), .tx_char(tx_char),
		.rx_word(rx_word), .rclk(rclk), .rclk_inv(rclk_inv), .rx_seen(rx_seen),
		.rx_count(rx_count)
	);
	// Far-end serial source; a steady line when off
	always @(posedge clk) begin
		bi <= (bi == 5'h13) ? 5'h00 : bi + 5'h01;
		rx_ser <= ext_on ? SER_PAT[bi] : 1'b0;
	end
	// ****
	// Shared tasks
	// ****
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic summarize();
		$display("comparisons %0d num_errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
			output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 50);
		htrans <= 2'h0;
		hwdata <= wd;
		do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 50);
		rd = hrdata;
		hsel <= 1'b0;
		if (n >= 50)
			check("bus wait", 32'h1, 32'h0);
	endtask
	task automatic next_word(output logic [9:0] w, output logic f, output logic inv);
		logic [15:0] c0;
		int          n;
		c0 = rx_count;
		n = 0;
		do begin @(negedge clk); n++; end while (rx_count === c0 && n < 40);
		w = rx_seen;
		f = comma;
		inv = rclk_inv;
		check("word spacing", {31'h0, (n <= 10)}, 32'h1);
		check("clock pair", {31'h0, rclk}, {31'h0, ~rclk_inv});
	endtask
	// ****
	// Scenarios
	// ****
	task automatic t_reset();
		repeat (3) @(posedge clk);
		@(negedge clk);
		check("reset tx", {30'h0, tx_p, tx_n}, 32'h2);
		check("reset clocks", {30'h0, rclk, rclk_inv}, 32'h1);
		check("reset rx", {20'h0, rx_word, comma, sig_valid}, 32'h0);
		check("reset bus", {29'h0, hreadyout, hresp, irq}, 32'h4);
		@(posedge clk);
		nrst <= 1'b1;
	endtask
	task automatic t_regs();
		logic [31:0] d;
		bus(`SWI_ADDR_CTRL, 1'b0, 32'h0, d);
		check("ctrl reset", d, 32'h0);
		bus(`SWI_ADDR_MASK, 1'b0, 32'h0, d);
		check("mask reset", d, 32'h0);
		bus(`SWI_ADDR_CTRL, 1'b1, 32'hffff_fffe, d);
		bus(`SWI_ADDR_CTRL, 1'b0, 32'h0, d);
		check("ctrl fields", d, 32'h2);
		bus(8'h10, 1'b1, 32'hffff_ffff, d);
		bus(8'h10, 1'b0, 32'h0, d);
		check("unmapped", d, 32'h0);
		bus(`SWI_ADDR_CTRL, 1'b1, 32'h0, d);
	endtask
	task automatic t_tx();
		logic [9:0]  h, h0;
		logic        hit;
		logic [31:0] d;
		char_a <= 10'h0e3;
		char_b <= 10'h0e3;
		h = 10'h000;
		h0 = 10'h000;
		hit = 1'b0;
		repeat (40) @(posedge clk);
		for (int i = 0; i < 20; i++) begin
			@(negedge clk);
			h = {tx_p, h[9:1]};
			if (i == 9)
				h0 = h;
			check("tx pair", {31'h0, tx_n}, {31'h0, ~tx_p});
		end
		for (int k = 0; k < 10; k++)
			if (((20'h38ce3 >> k) & 20'h003ff) == {10'h000, h})
				hit = 1'b1;
		check("tx order", {31'h0, hit}, 32'h1);
		check("tx period", {22'h0, h}, {22'h0, h0});
		@(posedge clk);
		loop_sel <= 1'b1;
		repeat (5) @(posedge clk);
		@(negedge clk);
		check("loop pin", {30'h0, tx_p, tx_n}, 32'h2);
		@(posedge clk);
		loop_sel <= 1'b0;
		bus(`SWI_ADDR_CTRL, 1'b1, 32'h1, d);
		repeat (3) @(posedge clk);
		@(negedge clk);
		check("loop reg", {30'h0, tx_p, tx_n}, 32'h2);
		bus(`SWI_ADDR_CTRL, 1'b1, 32'h0, d);
	endtask
	task automatic t_align(input logic [9:0] ca, input logic [9:0] cb);
		logic [9:0] w;
		logic       f, inv;
		int         n;
		@(posedge clk);
		char_a <= ca;
		char_b <= cb;
		align_en <= 1'b1;
		repeat (4) @(posedge clk);
		n = 0;
		do begin next_word(w, f, inv); n++; end while (w !== 10'h27c && n < 20);
		for (int i = 0; i < 6; i++) begin
			if (i > 0)
				next_word(w, f, inv);
			check("rx word", {22'h0, w}, (i % 2) ? 32'h0e3 : 32'h27c);
			check("flag phase", {30'h0, f, inv}, (i % 2) ? 32'h0 : 32'h3);
		end
		@(posedge clk);
		align_en <= 1'b0;
		next_word(w, f, inv);
		for (int i = 0; i < 6; i++) begin
			next_word(w, f, inv);
			check("align off", {30'h0, (w === 10'h27c || w === 10'h0e3), f}, 32'h2);
		end
	endtask
	task automatic t_sig();
		logic [31:0] d;
		check("valid live", {31'h0, sig_valid}, 32'h1);
		bus(`SWI_ADDR_STATUS, 1'b0, 32'h0, d);
		ext_on <= 1'b0;
		repeat (40) @(posedge clk);
		check("valid lost", {30'h0, sig_valid, irq}, 32'h0);
		bus(`SWI_ADDR_RXINFO, 1'b0, 32'h0, d);
		check("info valid", d & 32'h400, 32'h0);
		bus(`SWI_ADDR_MASK, 1'b1, 32'h4, d);
		repeat (2) @(posedge clk);
		check("irq raised", {31'h0, irq}, 32'h1);
		bus(`SWI_ADDR_STATUS, 1'b0, 32'h0, d);
		check("lost event", d & 32'h4, 32'h4);
		repeat (2) @(posedge clk);
		check("irq cleared", {31'h0, irq}, 32'h0);
	endtask
	// Whole run is a few hundred cycles
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		summarize();
	end
	initial begin
		nrst = 1'b0;
		rx_ser = 1'b0;
		bi = 5'h00;
		{ext_on, loop_sel, align_en, hsel, hwrite} = 5'h00;
		htrans = 2'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		char_a = 10'h000;
		char_b = 10'h000;
		t_reset();
		t_regs();
		t_tx();
		@(posedge clk);
		loop_sel <= 1'b1;
		t_align(10'h27c, 10'h0e3);
		@(posedge clk);
		loop_sel <= 1'b0;
		ext_on <= 1'b1;
		t_align(10'h155, 10'h155);
		t_sig();
		summarize();
	end
endmodule // swi_serdes_word_tb_top
`default_nettype wire
